/* pkg/gpio_port_pkg.sv */
// Package for the port A / port E general purpose I/O block.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
package gpio_port_pkg;
	localparam int unsigned ADDR_W = 6;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned REG_W  = 8;

	// Register byte addresses
	localparam logic [ADDR_W-1:0] OFS_PORT_A_PINS = 6'h00;
	localparam logic [ADDR_W-1:0] OFS_PORT_A_LAT  = 6'h04;
	localparam logic [ADDR_W-1:0] OFS_PORT_A_DIR  = 6'h08;
	localparam logic [ADDR_W-1:0] OFS_PORT_E_PINS = 6'h0C;
	localparam logic [ADDR_W-1:0] OFS_PORT_E_LAT  = 6'h10;
	localparam logic [ADDR_W-1:0] OFS_PORT_E_DIR  = 6'h14;
	localparam logic [ADDR_W-1:0] OFS_CONV_CFG    = 6'h18;
	localparam logic [ADDR_W-1:0] OFS_PORT_D_DATA = 6'h1C;
	localparam logic [ADDR_W-1:0] OFS_SYS_CFG     = 6'h20;

	// Reset values
	localparam logic [7:0] RST_PORT_A_DIR = 8'hFF;
	localparam logic [7:0] RST_PORT_E_DIR = 8'h07;
	localparam logic [7:0] RST_CONV_CFG   = 8'h00;
	localparam logic [7:0] RST_LAT        = 8'h00;
	localparam logic [2:0] RST_SYS_CFG    = 3'h0;

	// Field layouts
	localparam int unsigned PE_BITS     = 3;
	localparam int unsigned PE_IN_ONLY  = 3;
	localparam int unsigned DIRE_MODE   = 4;
	localparam int unsigned DIRE_OVF    = 5;
	localparam int unsigned DIRE_OUTF   = 6;
	localparam int unsigned DIRE_INF    = 7;
	localparam int unsigned CFG_PCFG_LO = 0;
	localparam int unsigned CFG_PCFG_HI = 3;
	localparam int unsigned CFG_W_MASK_HI = 5;
	localparam int unsigned SYS_OSC     = 0;
	localparam int unsigned SYS_MASTER_CLEAR_INPUT_EN = 1;
	localparam int unsigned SYS_POR     = 2;
	localparam logic [7:0] OSC_MASK     = 8'hC0;
	localparam logic [7:0] CONV_MASK    = 8'h3F;
	localparam logic [7:0] ANALOG_PINS  = 8'h2F;
	localparam logic [3:0] PCFG_ALL_DIG = 4'hF;
	localparam logic [3:0] PCFG_LEVELS  = 4'h7;
	localparam int unsigned PA_OD       = 4;

	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

/* logic/general_io_port_pins.sv */
// General purpose I/O port A (8 bits) and port E (3 bits plus input-only)
// with a parallel slave port on port D (strobes on port E), registers over AXI4-Lite.
// Assumes asynchronous pins; every pin input is synchronised first.
//
// Chosen here: the AXI4-Lite register port and the placing of the registers.
module general_io_port_pins #(
	parameter int unsigned PA_W = 8
) (
	input  wire logic                                i_sys_clk,
	input  wire logic                                i_rst,
	input  wire logic [gpio_port_pkg::ADDR_W-1:0]    i_awaddr,
	input  wire logic                                i_awvalid,
	output logic                                     o_awready,
	input  wire logic [gpio_port_pkg::DATA_W-1:0]    i_wdata,
	input  wire logic [3:0]                          i_wstrb,
	input  wire logic                                i_wvalid,
	output logic                                     o_wready,
	output logic [1:0]                               o_bresp,
	output logic                                     o_bvalid,
	input  wire logic                                i_bready,
	input  wire logic [gpio_port_pkg::ADDR_W-1:0]    i_araddr,
	input  wire logic                                i_arvalid,
	output logic                                     o_arready,
	output logic [gpio_port_pkg::DATA_W-1:0]         o_rdata,
	output logic [1:0]                               o_rresp,
	output logic                                     o_rvalid,
	input  wire logic                                i_rready,
	input  wire logic [PA_W-1:0]                     i_port_a_pin,
	output logic      [PA_W-1:0]                     o_port_a_pin,
	output logic      [PA_W-1:0]                     o_port_a_pin_oe,
	output logic      [PA_W-1:0]                     o_port_a_analog,
	input  wire logic [3:0]                          i_port_e_pin,
	output logic      [2:0]                          o_port_e_pin,
	output logic      [2:0]                          o_port_e_pin_oe,
	input  wire logic [7:0]                          i_port_d_pin,
	output logic      [7:0]                          o_port_d_pin,
	output logic      [7:0]                          o_port_d_pin_oe,
	output logic                                     o_schmitt_e,
	output logic                                     o_master_clear_n
);
	import gpio_port_pkg::*;

	logic [PA_W-1:0] pa_s1_ff, pa_s2_ff;
	logic [3:0]      pe_s1_ff, pe_s2_ff;
	logic [7:0]      pd_s1_ff, pd_s2_ff;
	logic [PA_W-1:0] pa_dir_ff, pa_lat_ff;
	logic [2:0]      pe_dir_ff, pe_lat_ff;
	logic [7:0]      conv_cfg_ff;
	logic [2:0]      sys_cfg_ff;
	logic            mode_ff, inf_ff, outf_ff, ovf_ff;
	logic [7:0]      pd_in_ff, pd_out_ff;
	logic            rd_act_ff, wr_act_ff;
	logic            aw_ff, w_ff;
	logic [ADDR_W-1:0] awaddr_ff;
	logic [7:0]      wbyte_ff;
	logic            wbyte_en_ff;

	// Two-stage synchronisers on every pin input
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			pa_s1_ff <= '0;
			pa_s2_ff <= '0;
			pe_s1_ff <= '1;
			pe_s2_ff <= '1;
			pd_s1_ff <= '0;
			pd_s2_ff <= '0;
		end else begin
			pa_s1_ff <= i_port_a_pin;
			pa_s2_ff <= pa_s1_ff;
			pe_s1_ff <= i_port_e_pin;
			pe_s2_ff <= pe_s1_ff;
			pd_s1_ff <= i_port_d_pin;
			pd_s2_ff <= pd_s1_ff;
		end
	end

	// Analog map from converter config
	logic [PA_W-1:0] analog_map;
	logic [PA_W-1:0] osc_map;
	always_comb begin
		analog_map = '0;
		if (conv_cfg_ff[CFG_PCFG_HI:CFG_PCFG_LO] <= PCFG_LEVELS)
			analog_map = PA_W'(ANALOG_PINS);
		osc_map = sys_cfg_ff[SYS_OSC] ? PA_W'(OSC_MASK) : '0;
	end

	logic slave_sel, rd_strobe, wr_strobe;
	assign slave_sel = mode_ff && !pe_s2_ff[2];
	assign rd_strobe = slave_sel && !pe_s2_ff[0];
	assign wr_strobe = slave_sel && !pe_s2_ff[1];

	// Write channel: address and data taken in either order
	logic wr_go;
	logic nxt_aw, nxt_w, nxt_bvalid;
	assign wr_go = aw_ff && w_ff && !o_bvalid;
	// Next channel state, so both ready outputs can come from flops
	always_comb begin
		nxt_aw     = aw_ff;
		nxt_w      = w_ff;
		nxt_bvalid = o_bvalid;
		if (i_awvalid && o_awready)
			nxt_aw = 1'b1;
		if (i_wvalid && o_wready)
			nxt_w = 1'b1;
		if (wr_go) begin
			nxt_aw     = 1'b0;
			nxt_w      = 1'b0;
			nxt_bvalid = 1'b1;
		end else if (o_bvalid && i_bready) begin
			nxt_bvalid = 1'b0;
		end
	end
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_awready   <= 1'b1;
			o_wready    <= 1'b1;
			aw_ff       <= 1'b0;
			w_ff        <= 1'b0;
			awaddr_ff   <= '0;
			wbyte_ff    <= '0;
			wbyte_en_ff <= 1'b0;
			o_bvalid    <= 1'b0;
			o_bresp     <= RESP_OKAY;
		end else begin
			o_awready <= !nxt_aw && !nxt_bvalid;
			o_wready  <= !nxt_w && !nxt_bvalid;
			if (i_awvalid && o_awready) begin
				aw_ff     <= 1'b1;
				awaddr_ff <= i_awaddr;
			end
			if (i_wvalid && o_wready) begin
				w_ff        <= 1'b1;
				wbyte_ff    <= i_wdata[REG_W-1:0];
				wbyte_en_ff <= i_wstrb[0];
			end
			if (wr_go) begin
				aw_ff    <= 1'b0;
				w_ff     <= 1'b0;
				o_bvalid <= 1'b1;
				o_bresp  <= addr_ok(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
			end else if (o_bvalid && i_bready) begin
				o_bvalid <= 1'b0;
			end
		end
	end

	function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
		addr_ok = a == OFS_PORT_A_PINS || a == OFS_PORT_A_LAT ||
			a == OFS_PORT_A_DIR || a == OFS_PORT_E_PINS ||
			a == OFS_PORT_E_LAT || a == OFS_PORT_E_DIR ||
			a == OFS_CONV_CFG || a == OFS_PORT_D_DATA ||
			a == OFS_SYS_CFG;
	endfunction

	logic do_wr;
	assign do_wr = wr_go && wbyte_en_ff;

	// Port A registers
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			pa_dir_ff <= PA_W'(RST_PORT_A_DIR);
			pa_lat_ff <= PA_W'(RST_LAT);
		end else if (do_wr) begin
			if (awaddr_ff == OFS_PORT_A_PINS ||
				awaddr_ff == OFS_PORT_A_LAT)
				pa_lat_ff <= PA_W'(wbyte_ff);
			if (awaddr_ff == OFS_PORT_A_DIR)
				pa_dir_ff <= PA_W'(wbyte_ff);
		end
	end

	// Port E and configuration registers
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			pe_dir_ff   <= RST_PORT_E_DIR[PE_BITS-1:0];
			pe_lat_ff   <= RST_LAT[PE_BITS-1:0];
			mode_ff     <= 1'b0;
			conv_cfg_ff <= RST_CONV_CFG;
			sys_cfg_ff  <= RST_SYS_CFG;
		end else if (do_wr) begin
			unique case (awaddr_ff)
				OFS_PORT_E_PINS, OFS_PORT_E_LAT:
					pe_lat_ff <= wbyte_ff[PE_BITS-1:0];
				OFS_PORT_E_DIR: begin
					pe_dir_ff <= wbyte_ff[PE_BITS-1:0];
					mode_ff   <= wbyte_ff[DIRE_MODE];
				end
				OFS_CONV_CFG:
					conv_cfg_ff <= wbyte_ff & CONV_MASK;
				OFS_SYS_CFG:
					sys_cfg_ff <= wbyte_ff[SYS_POR:SYS_OSC];
				default: ;
			endcase
		end
	end

	// Read request decode, shared with the slave-port flag clear
	logic [ADDR_W-1:0] ar_addr_q;
	logic              rd_en;
	assign ar_addr_q = i_araddr;
	assign rd_en = i_arvalid && o_arready;

	// Parallel slave port: strobe edges move port D data
	logic pe_rd_clr, pe_wr_clr;
	assign pe_rd_clr = rd_en && ar_addr_q == OFS_PORT_D_DATA;
	assign pe_wr_clr = do_wr && awaddr_ff == OFS_PORT_D_DATA;
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			rd_act_ff <= 1'b0;
			wr_act_ff <= 1'b0;
			inf_ff    <= 1'b0;
			outf_ff   <= 1'b0;
			ovf_ff    <= 1'b0;
			pd_in_ff  <= '0;
			pd_out_ff <= '0;
		end else begin
			rd_act_ff <= rd_strobe;
			wr_act_ff <= wr_strobe;
			// Set wins over a clear in the same cycle
			if (wr_act_ff && !wr_strobe) begin
				pd_in_ff <= pd_s2_ff;
				if (inf_ff && !pe_rd_clr)
					ovf_ff <= 1'b1;
				inf_ff <= 1'b1;
			end else if (pe_rd_clr) begin
				inf_ff <= 1'b0;
			end
			if (pe_wr_clr) begin
				pd_out_ff <= wbyte_ff;
				outf_ff   <= 1'b1;
			end else if (rd_act_ff && !rd_strobe) begin
				outf_ff <= 1'b0;
			end
			if (do_wr && awaddr_ff == OFS_PORT_E_DIR &&
				!wbyte_ff[DIRE_OVF] && !(wr_act_ff && !wr_strobe))
				ovf_ff <= 1'b0;
		end
	end

	// Read channel: one read in flight; ready is the registered inverse
	// of the next valid, so it tracks a decode of valid cycle for cycle
	logic nxt_rvalid;
	always_comb begin
		nxt_rvalid = o_rvalid;
		if (rd_en)
			nxt_rvalid = 1'b1;
		else if (o_rvalid && i_rready)
			nxt_rvalid = 1'b0;
	end

	logic [7:0] rd_byte;
	logic [PA_W-1:0] pa_pins_vis;
	always_comb begin
		// Analog and oscillator bits read zero in the pins register; latch and direction reads mask only the oscillator bits
		pa_pins_vis = pa_s2_ff & ~analog_map & ~osc_map;
		rd_byte = '0;
		unique case (ar_addr_q)
			OFS_PORT_A_PINS: rd_byte = 8'(pa_pins_vis);
			OFS_PORT_A_LAT:  rd_byte = 8'(pa_lat_ff & ~osc_map);
			OFS_PORT_A_DIR:  rd_byte = 8'(pa_dir_ff & ~osc_map);
			OFS_PORT_E_PINS: begin
				rd_byte[PE_BITS-1:0] = pe_s2_ff[PE_BITS-1:0];
				rd_byte[PE_IN_ONLY] = pe_s2_ff[PE_IN_ONLY] &
					~sys_cfg_ff[SYS_MASTER_CLEAR_INPUT_EN];
			end
			OFS_PORT_E_LAT:  rd_byte[PE_BITS-1:0] = pe_lat_ff;
			OFS_PORT_E_DIR: begin
				rd_byte[PE_BITS-1:0] = pe_dir_ff;
				rd_byte[DIRE_MODE] = mode_ff;
				rd_byte[DIRE_OVF]  = ovf_ff;
				rd_byte[DIRE_OUTF] = outf_ff;
				rd_byte[DIRE_INF]  = inf_ff;
			end
			OFS_CONV_CFG:    rd_byte = conv_cfg_ff;
			OFS_PORT_D_DATA: rd_byte = pd_in_ff;
			OFS_SYS_CFG:     rd_byte = 8'(sys_cfg_ff);
			default:         rd_byte = '0;
		endcase
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_rvalid  <= 1'b0;
			o_arready <= 1'b1;
			o_rdata   <= '0;
			o_rresp   <= RESP_OKAY;
		end else begin
			o_rvalid  <= nxt_rvalid;
			o_arready <= !nxt_rvalid;
			if (rd_en) begin
				o_rdata <= DATA_W'(rd_byte);
				o_rresp <= addr_ok(ar_addr_q) ? RESP_OKAY :
					RESP_SLVERR;
			end
		end
	end

	// Pin drivers
	genvar gi;
	generate
		for (gi = 0; gi < PA_W; gi++) begin : g_pa
			always_ff @(posedge i_sys_clk or posedge i_rst) begin
				if (i_rst) begin
					o_port_a_pin[gi]    <= 1'b0;
					o_port_a_pin_oe[gi] <= 1'b0;
					o_port_a_analog[gi] <= ANALOG_PINS[gi];
				end else begin
					o_port_a_analog[gi] <= analog_map[gi];
					if (osc_map[gi]) begin
						o_port_a_pin[gi]    <= 1'b0;
						o_port_a_pin_oe[gi] <= 1'b0;
					end else if (gi == PA_OD) begin
						// Open drain: only ever pulls low
						o_port_a_pin[gi]    <= 1'b0;
						o_port_a_pin_oe[gi] <= !pa_dir_ff[gi] &&
							!pa_lat_ff[gi];
					end else begin
						o_port_a_pin[gi]    <= pa_lat_ff[gi];
						o_port_a_pin_oe[gi] <= !pa_dir_ff[gi];
					end
				end
			end
		end
	endgenerate

	// Port E drivers; slave mode forces strobe pins to inputs
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_port_e_pin    <= '0;
			o_port_e_pin_oe <= '0;
		end else begin
			o_port_e_pin    <= pe_lat_ff;
			o_port_e_pin_oe <= mode_ff ? '0 : ~pe_dir_ff;
		end
	end

	// Port D drives only while an external read is under way
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_port_d_pin    <= '0;
			o_port_d_pin_oe <= '0;
		end else begin
			o_port_d_pin    <= pd_out_ff;
			o_port_d_pin_oe <= {8{rd_strobe}};
		end
	end

	// Buffer select and master clear; the clear uses the synced pin,
	// trading two cycles of latency for no metastable reset request
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_schmitt_e      <= 1'b1;
			o_master_clear_n <= 1'b1;
		end else begin
			o_schmitt_e      <= !mode_ff;
			o_master_clear_n <= !(sys_cfg_ff[SYS_MASTER_CLEAR_INPUT_EN] &&
				!pe_s2_ff[PE_IN_ONLY]);
		end
	end

endmodule // general_io_port_pins

/* tb/gpio_port_sva.sv */
// Checker for the port block, bound to its top module.
// Assumes one clock domain and an active high reset.
module gpio_port_sva #(
	parameter int unsigned PA_W = 8
) (
	input wire logic            i_sys_clk,
	input wire logic            i_rst,
	input wire logic            i_arvalid,
	input wire logic            o_arready,
	input wire logic            o_rvalid,
	input wire logic            i_rready,
	input wire logic [31:0]     o_rdata,
	input wire logic            o_bvalid,
	input wire logic            i_bready,
	input wire logic [1:0]      o_bresp,
	input wire logic            o_awready,
	input wire logic [PA_W-1:0] o_port_a_pin,
	input wire logic [PA_W-1:0] o_port_a_pin_oe,
	input wire logic [3:0]      i_port_e_pin,
	input wire logic [7:0]      o_port_d_pin_oe,
	input wire logic            o_schmitt_e,
	input wire logic            o_master_clear_n
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (i_rst);
	a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
		else $error("read not answered in one cycle");
	a_rdata_hold: assert property (o_rvalid && !i_rready |=>
		o_rvalid && $stable(o_rdata)) else $error("read data not held");
	a_bresp_hold: assert property (o_bvalid && !i_bready |=>
		o_bvalid && $stable(o_bresp)) else $error("write answer not held");
	a_aw_blocked: assert property (o_bvalid |-> !o_awready)
		else $error("address taken while answer pending");
	a_upper_zero: assert property (o_rvalid |-> o_rdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	a_drain_only: assert property (o_port_a_pin_oe[4] |-> !o_port_a_pin[4])
		else $error("open drain bit driven high");
	a_slave_ttl: assert property (|o_port_d_pin_oe |-> !o_schmitt_e)
		else $error("port D driven outside slave mode");
	a_read_idle: assert property (i_port_e_pin[0] [*5] |-> !(|o_port_d_pin_oe))
		else $error("port D driven without read strobe");
	a_cs_idle: assert property (i_port_e_pin[2] [*5] |-> !(|o_port_d_pin_oe))
		else $error("port D driven without chip select");
	a_clear_quiet: assert property (i_port_e_pin[3] [*5] |-> o_master_clear_n)
		else $error("master clear asserted with pin high");
endmodule // gpio_port_sva
bind general_io_port_pins gpio_port_sva #(.PA_W(PA_W)) sva_inst (
	.i_sys_clk, .i_rst, .i_arvalid, .o_arready, .o_rvalid, .i_rready,
	.o_rdata, .o_bvalid, .i_bready, .o_bresp, .o_awready, .o_port_a_pin,
	.o_port_a_pin_oe, .i_port_e_pin, .o_port_d_pin_oe, .o_schmitt_e,
	.o_master_clear_n
);

/* tb/pin_world.sv */
// External loads and drivers on ports A, D and E.
// Assumes board pull-ups on every port A and port D line.
module pin_world (
	input  wire logic [7:0] i_a_out,
	input  wire logic [7:0] i_a_oe,
	input  wire logic [7:0] i_a_ext,
	input  wire logic [7:0] i_a_ext_en,
	input  wire logic [7:0] i_d_out,
	input  wire logic [7:0] i_d_oe,
	input  wire logic [7:0] i_d_ext,
	input  wire logic       i_d_ext_en,
	input  wire logic [2:0] i_e_out,
	input  wire logic [2:0] i_e_oe,
	input  wire logic [2:0] i_e_ext,
	output logic      [7:0] o_a_wire,
	output logic      [7:0] o_d_wire,
	output logic      [2:0] o_e_wire
);
	timeunit 1ns;
	timeprecision 1ps;
	// Released open drain line floats up
	assign o_a_wire = (i_a_oe & i_a_out) | (~i_a_oe & i_a_ext_en & i_a_ext)
		| (~i_a_oe & ~i_a_ext_en);
	// Slave read data appears only while the block drives
	assign o_d_wire = (i_d_oe & i_d_out) | (~i_d_oe & (i_d_ext_en ? i_d_ext
		: 8'hFF));
	assign o_e_wire = (i_e_oe & i_e_out) | (~i_e_oe & i_e_ext);
endmodule // pin_world

/* tb/tb.sv */
// Self-checking bench for the port block over AXI4-Lite.
// Assumes the pin world model and bound checker are compiled first.
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
	$display("ERROR %0t mismatch got %0h exp %0h", $time, g, e); end end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import gpio_port_pkg::*;
	logic clk = 1'b0, rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0;
	logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0, d_ext_en = 1'b0;
	logic e3 = 1'b1;
	logic [5:0] awaddr = 6'h00, araddr = 6'h00;
	logic [31:0] wdata = 32'h0;
	logic [7:0] a_ext = 8'h00, a_ext_en = 8'h00, d_ext = 8'h00;
	logic [2:0] strb_n = 3'h7;
	logic [1:0] resp;
	logic [31:0] rd_val;
	int fail_count = 0, num_checks = 0;
	wire awready, wready, bvalid, arready, rvalid, schmitt, master_clear_input_n;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [7:0] a_out, a_oe, a_an, a_wire, d_out, d_oe, d_wire;
	wire [2:0] e_out, e_oe, e_wire;
	always #4 clk = ~clk;
	general_io_port_pins general_io_port_pins_inst (.i_sys_clk(clk),
		.i_rst(rst), .i_awaddr(awaddr), .i_awvalid(awvalid),
		.o_awready(awready), .i_wdata(wdata), .i_wstrb(4'h1),
		.i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
		.o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
		.i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
		.o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
		.i_port_a_pin(a_wire), .o_port_a_pin(a_out), .o_port_a_pin_oe(a_oe),
		.o_port_a_analog(a_an), .i_port_e_pin({e3, e_wire}),
		.o_port_e_pin(e_out), .o_port_e_pin_oe(e_oe), .i_port_d_pin(d_wire),
		.o_port_d_pin(d_out), .o_port_d_pin_oe(d_oe), .o_schmitt_e(schmitt),
		.o_master_clear_n(master_clear_input_n));
	pin_world pin_world_inst (.i_a_out(a_out), .i_a_oe(a_oe), .i_a_ext(a_ext),
		.i_a_ext_en(a_ext_en), .i_d_out(d_out), .i_d_oe(d_oe),
		.i_d_ext(d_ext), .i_d_ext_en(d_ext_en), .i_e_out(e_out),
		.i_e_oe(e_oe), .i_e_ext(strb_n), .o_a_wire(a_wire),
		.o_d_wire(d_wire), .o_e_wire(e_wire));
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Handshakes judged at the falling edge, acted on at the next rise
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		logic ha, hw, hb;
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		hb = 1'b0;
		while (!hb) begin
			@(negedge clk);
			ha = awvalid & awready;
			hw = wvalid & wready;
			hb = bvalid;
			resp = bresp;
			@(posedge clk);
			if (ha) awvalid <= 1'b0;
			if (hw) wvalid <= 1'b0;
		end
		bready <= 1'b0;
		tick(1);
	endtask
	task automatic rd(input logic [5:0] a);
		logic ha, hr;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		hr = 1'b0;
		while (!hr) begin
			@(negedge clk);
			ha = arvalid & arready;
			hr = rvalid;
			rd_val = rdata;
			resp = rresp;
			@(posedge clk);
			if (ha) arvalid <= 1'b0;
		end
		rready <= 1'b0;
		tick(1);
	endtask
	task automatic chk(input logic [5:0] a, input logic [7:0] e);
		rd(a);
		`CHK(rd_val, {24'h0, e})
		`CHK(resp, RESP_OKAY)
	endtask
	// Write strobe released before chip select so capture sees it selected
	task automatic ext_wr(input logic cs_n, input logic [7:0] v);
		d_ext <= v;
		d_ext_en <= 1'b1;
		strb_n <= {cs_n, 2'b01};
		tick(4);
		strb_n <= {cs_n, 2'b11};
		tick(4);
		strb_n <= 3'h7;
		d_ext_en <= 1'b0;
		tick(4);
	endtask
	task automatic t_reset;
		chk(OFS_PORT_A_DIR, 8'hFF);
		chk(OFS_PORT_E_DIR, 8'h07);
		chk(OFS_CONV_CFG, 8'h00);
		`CHK(a_an, 8'h2F)
		`CHK(a_oe, 8'h00)
		chk(OFS_PORT_A_PINS, 8'hD0);
	endtask
	task automatic t_port_a;
		wr(OFS_CONV_CFG, 8'h0F);
		wr(OFS_PORT_A_DIR, 8'h2F);
		wr(OFS_PORT_A_PINS, 8'h5A);
		a_ext <= 8'h03;
		a_ext_en <= 8'h0F;
		tick(4);
		`CHK(a_oe, 8'hC0)
		`CHK(a_out & a_oe, 8'h40)
		chk(OFS_PORT_A_PINS, 8'h73);
		chk(OFS_PORT_A_LAT, 8'h5A);
		wr(OFS_CONV_CFG, 8'h00);
		tick(4);
		`CHK(a_an, 8'h2F)
		chk(OFS_PORT_A_PINS, 8'h50);
		wr(OFS_CONV_CFG, 8'h0F);
		tick(4);
		`CHK(a_an, 8'h00)
	endtask
	task automatic t_osc;
		wr(OFS_SYS_CFG, 8'h01);
		tick(4);
		`CHK(a_oe, 8'h00)
		chk(OFS_PORT_A_PINS, 8'h33);
		chk(OFS_PORT_A_LAT, 8'h1A);
		chk(OFS_PORT_A_DIR, 8'h2F);
		wr(OFS_SYS_CFG, 8'h00);
	endtask
	task automatic t_port_e;
		wr(OFS_PORT_E_LAT, 8'hFF);
		chk(OFS_PORT_E_LAT, 8'h07);
		wr(OFS_PORT_E_DIR, 8'h08);
		chk(OFS_PORT_E_DIR, 8'h00);
		`CHK(e_oe, 3'h7)
		`CHK(e_out, 3'h7)
		chk(OFS_PORT_E_PINS, 8'h0F);
		wr(OFS_PORT_E_PINS, 8'h05);
		chk(OFS_PORT_E_LAT, 8'h05);
		wr(OFS_SYS_CFG, 8'h02);
		e3 <= 1'b0;
		tick(4);
		`CHK(master_clear_input_n, 1'b0)
		chk(OFS_PORT_E_PINS, 8'h05);
		e3 <= 1'b1;
		wr(OFS_SYS_CFG, 8'h00);
		wr(OFS_PORT_E_DIR, 8'h07);
	endtask
	task automatic t_slave;
		wr(OFS_PORT_E_DIR, 8'h17);
		tick(3);
		`CHK(schmitt, 1'b0)
		ext_wr(1'b1, 8'hAA);
		chk(OFS_PORT_E_DIR, 8'h17);
		ext_wr(1'b0, 8'hC3);
		chk(OFS_PORT_E_DIR, 8'h97);
		chk(OFS_PORT_D_DATA, 8'hC3);
		wr(OFS_PORT_D_DATA, 8'h3C);
		chk(OFS_PORT_E_DIR, 8'h57);
		strb_n <= 3'h2;
		tick(4);
		`CHK(d_oe, 8'hFF)
		`CHK(d_wire, 8'h3C)
		strb_n <= 3'h3;
		tick(4);
		strb_n <= 3'h7;
		chk(OFS_PORT_E_DIR, 8'h17);
		ext_wr(1'b0, 8'h11);
		ext_wr(1'b0, 8'h22);
		chk(OFS_PORT_E_DIR, 8'hB7);
	endtask
	task automatic t_unmapped;
		rd(6'h3C);
		`CHK(resp, RESP_SLVERR)
		`CHK(rd_val, 32'h0)
		wr(6'h24, 8'h55);
		`CHK(resp, RESP_SLVERR)
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Whole run needs a few hundred cycles; over fifty times that is a hang
	initial begin
		#100000;
		fail_count++;
		wrap_up();
	end
	initial begin
		tick(5);
		rst <= 1'b0;
		tick(1);
		t_reset();
		t_port_a();
		t_osc();
		t_port_e();
		t_slave();
		t_unmapped();
		wrap_up();
	end
endmodule // tb
